// ### hw/gprr_top.sv
// Gigabit PHY master/slave role resolver with page exchange and registers
//
// What this block does
// - PHY negotiates and can end up either MASTER or SLAVE.
// - Exchange base, formatted and two unformatted pages back to back.
// - With energy option, add one formatted and one unformatted page.
// - Role comes from own manual, multiport and seed settings combined with the partner's.
// - Successful resolution raises the resolution-complete indication.
// - A resolution fault also raises resolution-complete.
// - A counter tracks how many seeds have been tried.
// - Seed counter is zero at start-up.
// - Seed counter steps by one whenever a new seed is sent.
// - On successful completion the seed counter and fault bit go to zero.
// - Higher seed becomes MASTER, lower seed becomes SLAVE.
// - Both ends forced to the same role is a fault.
// - A fault sets the fault status bit to one.
// - A fault forces the gigabit link state to FAIL.
`include "gprr_defines.svh"

module gprr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic pma_link_ok,
  output logic tx_page_valid,
  output logic [15:0] tx_page_data,
  input wire logic rx_page_valid,
  input wire logic [15:0] rx_page_data,
  output logic res_done,
  output logic role_master,
  output logic res_fault,
  output logic gigabit_link_state,
  output logic irq
);

  typedef struct packed {
    gprr_pkg::gprr_fsm_t fsm;
    logic man_en;
    logic man_mst;
    logic multi;
    logic energy_efficient_option;
    logic [15:0] ability;
    logic [1:0] irq_st;
    logic [1:0] irq_en;
    logic [`GPRR_SEED_W-1:0] seed;
    logic [2:0] cnt;
    logic [15:0] rem_u1;
    logic go;
    logic done;
    logic master;
    logic fault;
    logic link;
    logic irq;
    logic [31:0] rdata;
  } gprr_top_st_t;

  gprr_top_st_t st_q, st_d;
  logic [`GPRR_SEED_W-1:0] new_seed;
  logic [15:0] page_word;
  logic [2:0] seq_idx;
  logic seq_done;
  logic [1:0] ev;
  gprr_pkg::gprr_res_t res;

  // Page contents for the current index of the sequencer
  function automatic logic [15:0] gprr_page(
    input logic [2:0] i,
    input gprr_top_st_t s
  );
    logic [15:0] w;
    w = 16'h0000;
    case (i)
      3'h0: w = s.ability;
      3'h1: w = `GPRR_FNP_MSG;
      3'h2: begin
        w[`GPRR_SEED_W-1:0] = s.seed;
        w[`GPRR_U1_MAN_EN] = s.man_en;
        w[`GPRR_U1_MAN_MST] = s.man_mst;
        w[`GPRR_U1_MULTI] = s.multi;
      end
      3'h4: w = `GPRR_FNP_EEO;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : gprr_page

  // Combine local settings with the partner's unformatted page
  function automatic gprr_pkg::gprr_res_t gprr_resolve(
    input gprr_top_st_t s
  );
    logic rm;
    logic rmst;
    logic [`GPRR_SEED_W-1:0] rseed;
    gprr_pkg::gprr_res_t r;
    rm = s.rem_u1[`GPRR_U1_MAN_EN];
    rmst = s.rem_u1[`GPRR_U1_MAN_MST];
    rseed = s.rem_u1[`GPRR_SEED_W-1:0];
    r = gprr_pkg::GPRR_RES_RETRY;
    if (s.man_en && rm) begin
      if (s.man_mst == rmst) begin
        r = gprr_pkg::GPRR_RES_FAULT;
      end else begin
        r = s.man_mst ? gprr_pkg::GPRR_RES_MASTER : gprr_pkg::GPRR_RES_SLAVE;
      end
    end else if (s.man_en) begin
      r = s.man_mst ? gprr_pkg::GPRR_RES_MASTER : gprr_pkg::GPRR_RES_SLAVE;
    end else if (rm) begin
      r = rmst ? gprr_pkg::GPRR_RES_SLAVE : gprr_pkg::GPRR_RES_MASTER;
    end else if (s.multi != s.rem_u1[`GPRR_U1_MULTI]) begin
      // A multiport device prefers to source the clock
      r = s.multi ? gprr_pkg::GPRR_RES_MASTER : gprr_pkg::GPRR_RES_SLAVE;
    end else if (s.seed > rseed) begin
      r = gprr_pkg::GPRR_RES_MASTER;
    end else if (s.seed < rseed) begin
      r = gprr_pkg::GPRR_RES_SLAVE;
    end
    return r;
  endfunction : gprr_resolve

  gprr_seed_lfsr u_seed (
    .clk(clk),
    .rst_n(rst_n),
    .seed(new_seed)
  );

  gprr_page_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .go(st_q.go),
    .six_pages(st_q.energy_efficient_option),
    .page_word(page_word),
    .rx_valid(rx_page_valid),
    .tx_valid(tx_page_valid),
    .tx_data(tx_page_data),
    .idx(seq_idx),
    .done(seq_done)
  );

  assign page_word = gprr_page(seq_idx, st_q);
  assign res = gprr_resolve(st_q);

  // Resolver, register file and interrupt logic in one next-state copy
  always_comb begin
    st_d = st_q;
    st_d.go = 1'b0;
    ev = 2'b00;
    // Register writes; start only acts when no exchange is running
    if (reg_we) begin
      case (reg_addr)
        `GPRR_OFS_CTRL: begin
          st_d.man_en = reg_wdata[`GPRR_CTRL_MAN_EN];
          st_d.man_mst = reg_wdata[`GPRR_CTRL_MAN_MST];
          st_d.multi = reg_wdata[`GPRR_CTRL_MULTI];
          st_d.energy_efficient_option = reg_wdata[`GPRR_CTRL_EEO];
          if (reg_wdata[`GPRR_CTRL_START] &&
              st_q.fsm != gprr_pkg::GPRR_EXCH &&
              st_q.fsm != gprr_pkg::GPRR_RESOLVE) begin
            st_d.seed = new_seed;
            st_d.go = 1'b1;
            st_d.done = 1'b0;
            // Fresh start gets all seven attempts; a kept count would wrap
            st_d.cnt = 3'h0;
            st_d.fsm = gprr_pkg::GPRR_EXCH;
          end
        end
        `GPRR_OFS_ABILITY: st_d.ability = reg_wdata[15:0];
        `GPRR_OFS_IRQ_EN: st_d.irq_en = reg_wdata[1:0];
        `GPRR_OFS_IRQ_CLR: st_d.irq_st = st_q.irq_st & ~reg_wdata[1:0];
        default: st_d.irq_en = st_q.irq_en;
      endcase
    end
    // Each seed page that goes out counts as one attempt
    if (tx_page_valid && seq_idx == `GPRR_IDX_UNP1) begin
      st_d.cnt = 3'(st_q.cnt + 3'h1);
    end
    // Keep the partner's seed page for the role decision
    if (rx_page_valid && seq_idx == `GPRR_IDX_UNP1 &&
        st_q.fsm == gprr_pkg::GPRR_EXCH) begin
      st_d.rem_u1 = rx_page_data;
    end
    case (st_q.fsm)
      gprr_pkg::GPRR_EXCH: begin
        if (seq_done) begin
          st_d.fsm = gprr_pkg::GPRR_RESOLVE;
        end
      end
      gprr_pkg::GPRR_RESOLVE: begin
        if (res == gprr_pkg::GPRR_RES_MASTER ||
            res == gprr_pkg::GPRR_RES_SLAVE) begin
          st_d.master = (res == gprr_pkg::GPRR_RES_MASTER);
          st_d.done = 1'b1;
          st_d.fault = 1'b0;
          st_d.cnt = 3'h0;
          ev[`GPRR_EV_DONE] = 1'b1;
          st_d.fsm = gprr_pkg::GPRR_DONE;
        end else if (res == gprr_pkg::GPRR_RES_FAULT ||
                     st_q.cnt >= `GPRR_MAX_SEEDS) begin
          st_d.done = 1'b1;
          st_d.fault = 1'b1;
          st_d.master = 1'b0;
          ev = 2'b11;
          st_d.fsm = gprr_pkg::GPRR_FAULT;
        end else begin
          // Tie on seeds: draw again and rerun the whole page set
          st_d.seed = new_seed;
          st_d.go = 1'b1;
          st_d.fsm = gprr_pkg::GPRR_EXCH;
        end
      end
      gprr_pkg::GPRR_IDLE, gprr_pkg::GPRR_DONE, gprr_pkg::GPRR_FAULT: begin
        st_d.fsm = st_d.fsm;
      end
      default: st_d.fsm = gprr_pkg::GPRR_IDLE;
    endcase
    // Events set after the clear so a same-cycle event is never lost
    st_d.irq_st = st_d.irq_st | ev;
    st_d.irq = |(st_d.irq_st & st_d.irq_en);
    // A fault drags the gigabit link down in the same edge
    st_d.link = pma_link_ok && !st_d.fault;
    // Read data stands only in the cycle after the strobe
    st_d.rdata = 32'h0000_0000;
    if (reg_re) begin
      case (reg_addr)
        `GPRR_OFS_CTRL: begin
          st_d.rdata[`GPRR_CTRL_MAN_EN] = st_q.man_en;
          st_d.rdata[`GPRR_CTRL_MAN_MST] = st_q.man_mst;
          st_d.rdata[`GPRR_CTRL_MULTI] = st_q.multi;
          st_d.rdata[`GPRR_CTRL_EEO] = st_q.energy_efficient_option;
        end
        `GPRR_OFS_STATUS: begin
          st_d.rdata[`GPRR_STAT_DONE] = st_q.done;
          st_d.rdata[`GPRR_STAT_MASTER] = st_q.master;
          st_d.rdata[`GPRR_STAT_FAULT] = st_q.fault;
          st_d.rdata[`GPRR_STAT_LINK] = st_q.link;
          st_d.rdata[`GPRR_STAT_CNT_LSB +: 3] = st_q.cnt;
        end
        `GPRR_OFS_IRQ_STAT: st_d.rdata[1:0] = st_q.irq_st;
        `GPRR_OFS_IRQ_EN: st_d.rdata[1:0] = st_q.irq_en;
        `GPRR_OFS_ABILITY: st_d.rdata[15:0] = st_q.ability;
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Counter and fault bit start cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.fsm <= gprr_pkg::GPRR_IDLE;
      st_q.ability <= `GPRR_RST_ABIL;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign res_done = st_q.done;
  assign role_master = st_q.master;
  assign res_fault = st_q.fault;
  assign gigabit_link_state = st_q.link;
  assign irq = st_q.irq;

  default clocking gprr_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_fault_link: assert property (
    res_fault |-> !gigabit_link_state)
    else $error("link state not FAIL during fault");

  chk_cnt_bound: assert property (
    st_q.cnt <= `GPRR_MAX_SEEDS)
    else $error("seed counter passed seven");

  chk_ok_clears: assert property (
    $rose(res_done) && !res_fault |-> st_q.cnt == 3'h0)
    else $error("counter not cleared on completion");

  chk_fault_done: assert property (
    $rose(res_fault) |-> res_done && $past(st_q.fsm) ==
    gprr_pkg::GPRR_RESOLVE)
    else $error("fault without completion");

  chk_manual_same: assert property (
    st_q.fsm == gprr_pkg::GPRR_RESOLVE && st_q.man_en &&
    st_q.rem_u1[`GPRR_U1_MAN_EN] &&
    st_q.man_mst == st_q.rem_u1[`GPRR_U1_MAN_MST] |=> res_fault)
    else $error("same manual roles not faulted");

  chk_seed_role: assert property (
    st_q.fsm == gprr_pkg::GPRR_RESOLVE && !st_q.man_en &&
    !st_q.rem_u1[`GPRR_U1_MAN_EN] &&
    st_q.multi == st_q.rem_u1[`GPRR_U1_MULTI] &&
    st_q.seed != st_q.rem_u1[`GPRR_SEED_W-1:0] |=>
    res_done && !res_fault &&
    role_master == ($past(st_q.seed) >
                    $past(st_q.rem_u1[`GPRR_SEED_W-1:0])))
    else $error("seed comparison gave wrong role");

  chk_cnt_step: assert property (
    tx_page_valid && seq_idx == `GPRR_IDX_UNP1 |=>
    st_q.cnt == 3'($past(st_q.cnt) + 3'h1))
    else $error("seed counter missed a step");

  chk_retry_go: assert property (
    st_q.fsm == gprr_pkg::GPRR_RESOLVE &&
    res == gprr_pkg::GPRR_RES_RETRY && st_q.cnt < `GPRR_MAX_SEEDS |=>
    st_q.fsm == gprr_pkg::GPRR_EXCH ##2 tx_page_valid)
    else $error("tie did not restart the exchange");

  chk_irq_level: assert property (
    irq |-> |(st_q.irq_st & st_q.irq_en))
    else $error("interrupt without enabled status");

  cov_success_master: cover property (
    $rose(res_done) && role_master && !res_fault);
  cov_manual_fault: cover property (
    $rose(res_fault) && st_q.man_en);
  cov_seed_retry: cover property (
    st_q.fsm == gprr_pkg::GPRR_RESOLVE &&
    res == gprr_pkg::GPRR_RES_RETRY);

endmodule : gprr_top

// ### shared/gprr_defines.svh
// Offsets, field positions, reset values and counts of the role resolver
`ifndef GPRR_DEFINES_SVH
`define GPRR_DEFINES_SVH

// Register offsets (byte addresses, one word each)
`define GPRR_OFS_CTRL 8'h00
`define GPRR_OFS_STATUS 8'h04
`define GPRR_OFS_IRQ_STAT 8'h08
`define GPRR_OFS_IRQ_CLR 8'h0C
`define GPRR_OFS_IRQ_EN 8'h10
`define GPRR_OFS_ABILITY 8'h14

// Control register bits
`define GPRR_CTRL_START 0
`define GPRR_CTRL_MAN_EN 1
`define GPRR_CTRL_MAN_MST 2
`define GPRR_CTRL_MULTI 3
`define GPRR_CTRL_EEO 4

// Status register bits
`define GPRR_STAT_DONE 0
`define GPRR_STAT_MASTER 1
`define GPRR_STAT_FAULT 2
`define GPRR_STAT_LINK 3
`define GPRR_STAT_CNT_LSB 4

// Interrupt event bits
`define GPRR_EV_DONE 0
`define GPRR_EV_FAULT 1

// Seed and page layout
`define GPRR_SEED_W 11
`define GPRR_U1_MAN_EN 15
`define GPRR_U1_MAN_MST 14
`define GPRR_U1_MULTI 13
`define GPRR_IDX_UNP1 3'h2
`define GPRR_FNP_MSG 16'h2008
`define GPRR_FNP_EEO 16'h200A

// Counts and reset values
`define GPRR_MAX_SEEDS 3'h7
`define GPRR_PAGES_STD 3'h4
`define GPRR_PAGES_EEO 3'h6
`define GPRR_RST_ABIL 16'h0001
`define GPRR_LFSR_INIT 11'h5A5

`endif

// ### shared/gprr_pkg.sv
// Types shared by the role resolver modules
package gprr_pkg;

  // Resolver states, Gray coded along idle, exchange, resolve, done
  typedef enum logic [2:0] {
    GPRR_IDLE = 3'h0,
    GPRR_EXCH = 3'h1,
    GPRR_RESOLVE = 3'h3,
    GPRR_DONE = 3'h2,
    GPRR_FAULT = 3'h6
  } gprr_fsm_t;

  // Page sequencer states
  typedef enum logic [1:0] {
    GPRR_SQ_IDLE = 2'h0,
    GPRR_SQ_SEND = 2'h1,
    GPRR_SQ_WAIT = 2'h3
  } gprr_sq_t;

  // Outcome of one resolution pass
  typedef enum logic [1:0] {
    GPRR_RES_SLAVE = 2'h0,
    GPRR_RES_MASTER = 2'h1,
    GPRR_RES_FAULT = 2'h2,
    GPRR_RES_RETRY = 2'h3
  } gprr_res_t;

endpackage : gprr_pkg

// ### hw/gprr_seed_lfsr.sv
// Free-running seed source for role resolution
`include "gprr_defines.svh"

module gprr_seed_lfsr (
  input wire logic clk,
  input wire logic rst_n,
  output logic [`GPRR_SEED_W-1:0] seed
);

  typedef struct packed {
    logic [`GPRR_SEED_W-1:0] lfsr;
  } gprr_lfsr_st_t;

  gprr_lfsr_st_t st_q, st_d;

  // Galois step; runs every cycle so the seed depends on start time
  always_comb begin
    st_d = st_q;
    st_d.lfsr = {1'b0, st_q.lfsr[`GPRR_SEED_W-1:1]};
    if (st_q.lfsr[0]) begin
      st_d.lfsr = st_d.lfsr ^ 11'h500;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q.lfsr <= `GPRR_LFSR_INIT;
    end else begin
      st_q <= st_d;
    end
  end

  assign seed = st_q.lfsr;

  // A zero state would lock the register for good
  chk_lfsr_nonzero: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.lfsr != 11'h000) else $error("seed source stuck at zero");

endmodule : gprr_seed_lfsr

// ### hw/gprr_page_seq.sv
// Sends the negotiation pages back to back, one per partner page
`include "gprr_defines.svh"

module gprr_page_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic six_pages,
  input wire logic [15:0] page_word,
  input wire logic rx_valid,
  output logic tx_valid,
  output logic [15:0] tx_data,
  output logic [2:0] idx,
  output logic done
);

  typedef struct packed {
    gprr_pkg::gprr_sq_t fsm;
    logic [2:0] idx;
    logic [2:0] last;
    logic tx_valid;
    logic [15:0] tx_data;
    logic done;
  } gprr_seq_st_t;

  gprr_seq_st_t st_q, st_d;

  // One page out, wait for the partner's page, then the next two cycles after it
  always_comb begin
    st_d = st_q;
    st_d.tx_valid = 1'b0;
    st_d.done = 1'b0;
    case (st_q.fsm)
      gprr_pkg::GPRR_SQ_SEND: begin
        st_d.tx_valid = 1'b1;
        st_d.tx_data = page_word;
        st_d.fsm = gprr_pkg::GPRR_SQ_WAIT;
      end
      gprr_pkg::GPRR_SQ_WAIT: begin
        if (rx_valid) begin
          if (st_q.idx == st_q.last) begin
            st_d.done = 1'b1;
            st_d.fsm = gprr_pkg::GPRR_SQ_IDLE;
          end else begin
            st_d.idx = 3'(st_q.idx + 3'h1);
            st_d.fsm = gprr_pkg::GPRR_SQ_SEND;
          end
        end
      end
      default: begin
        st_d.fsm = gprr_pkg::GPRR_SQ_IDLE;
      end
    endcase
    // A new go restarts the sequence from the base page
    if (go) begin
      st_d.idx = 3'h0;
      st_d.last = six_pages ? 3'(`GPRR_PAGES_EEO - 3'h1) :
                              3'(`GPRR_PAGES_STD - 3'h1);
      st_d.fsm = gprr_pkg::GPRR_SQ_SEND;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tx_valid = st_q.tx_valid;
  assign tx_data = st_q.tx_data;
  assign idx = st_q.idx;
  assign done = st_q.done;

  chk_next_page: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.fsm == gprr_pkg::GPRR_SQ_WAIT && rx_valid && !go &&
    st_q.idx != st_q.last |-> ##2 tx_valid)
    else $error("next page not sent two cycles after partner page");

endmodule : gprr_page_seq

// ### testbench/gprr_link_partner.sv
// Behavioural far-end PHY answering each page of the resolver
`include "gprr_defines.svh"

module gprr_link_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic six,
  input wire logic man_en,
  input wire logic man_mst,
  input wire logic [2:0] ties,
  input wire logic [10:0] seed,
  input wire logic [1:0] lag,
  input wire logic tx_page_valid,
  input wire logic [15:0] tx_page_data,
  output logic rx_page_valid,
  output logic [15:0] rx_page_data,
  output logic [15:0] n_rx,
  output logic [10:0] ds_q,
  output logic [10:0] ps_q,
  output logic [15:0] n_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] idx_q;
  logic [2:0] att_q;
  logic [1:0] wait_q;
  logic pend_q;
  logic [10:0] s;
  logic [15:0] word;

  // Echo the device seed while ties remain, else never equal to it
  always_comb begin
    s = (seed == ds_q) ? (seed ^ 11'h001) : seed;
    if (att_q < ties) s = ds_q;
    case (idx_q)
      3'h0: word = 16'h0001;
      3'h1: word = `GPRR_FNP_MSG;
      3'h2: word = {man_en, man_mst, 3'h0, s};
      3'h4: word = `GPRR_FNP_EEO;
      default: word = 16'h0000;
    endcase
  end

  // One answer per page, after a chosen lag; idle data is scrambled
  always_ff @(posedge clk) begin
    if (!rst_n || arm) begin
      pend_q <= 1'b0;
      idx_q <= 3'h0;
      att_q <= 3'h0;
      n_rx <= 16'h0000;
      n_bad <= 16'h0000;
      rx_page_valid <= 1'b0;
      rx_page_data <= 16'h0000;
      wait_q <= 2'h0;
    end else begin
      rx_page_valid <= 1'b0;
      if (rx_page_valid) rx_page_data <= ~rx_page_data;
      if (tx_page_valid) begin
        pend_q <= 1'b1;
        wait_q <= lag;
        if (idx_q == 3'h2) ds_q <= tx_page_data[10:0];
        // Fixed pages must carry their fixed words
        if ((idx_q == 3'h1 && tx_page_data != `GPRR_FNP_MSG) ||
            (idx_q == 3'h4 && tx_page_data != `GPRR_FNP_EEO) ||
            (idx_q[0] && idx_q != 3'h1 && tx_page_data != 16'h0000)) begin
          n_bad <= n_bad + 16'h0001;
        end
      end else if (pend_q && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (pend_q) begin
        rx_page_valid <= 1'b1;
        rx_page_data <= word;
        pend_q <= 1'b0;
        n_rx <= n_rx + 16'h0001;
        idx_q <= (idx_q == (six ? 3'h5 : 3'h3)) ? 3'h0 : idx_q + 3'h1;
        if (idx_q == 3'h2) begin
          att_q <= att_q + 3'h1;
          ps_q <= s;
        end
      end
    end
  end
endmodule : gprr_link_partner

// ### testbench/tb.sv
// Self-checking bench for the role resolver with a behavioural partner
`include "gprr_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] v;
    logic [31:0] m;
    logic pins;
    logic irq_e;
    string nm;
  } gprr_exp_t;
  logic clk, rst_n, reg_we, reg_re, pma_link_ok, tx_page_valid;
  logic rx_page_valid, res_done, role_master, res_fault;
  logic gigabit_link_state, irq, arm, six, pm, pmm, re_q, mlt;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rs;
  logic [15:0] tx_page_data, rx_page_data, n_rx, n_bad;
  logic [10:0] p_seed, ds_q, ps_q;
  logic [2:0] ties;
  logic [1:0] lag, ev_m, en_m;
  logic [3:0] mt [5];
  gprr_exp_t q[$];
  gprr_exp_t e;
  int n_fail, n_checks;

  gprr_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .pma_link_ok(pma_link_ok),
    .tx_page_valid(tx_page_valid), .tx_page_data(tx_page_data),
    .rx_page_valid(rx_page_valid), .rx_page_data(rx_page_data),
    .res_done(res_done), .role_master(role_master), .res_fault(res_fault),
    .gigabit_link_state(gigabit_link_state), .irq(irq));

  gprr_link_partner p (.clk(clk), .rst_n(rst_n), .arm(arm), .six(six),
    .man_en(pm), .man_mst(pmm), .ties(ties), .seed(p_seed), .lag(lag),
    .tx_page_valid(tx_page_valid), .tx_page_data(tx_page_data),
    .rx_page_valid(rx_page_valid), .rx_page_data(rx_page_data),
    .n_rx(n_rx), .ds_q(ds_q), .ps_q(ps_q), .n_bad(n_bad));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  task conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr

  // Notes the expected word, pins and interrupt, then issues the read
  task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
          input logic pins, input string nm);
    gprr_exp_t x;
    x.v = v;
    x.m = m;
    x.pins = pins;
    x.irq_e = |(ev_m & en_m);
    x.nm = nm;
    @(posedge clk);
    q.push_back(x);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
  endtask : rd

  // One full negotiation; {dm,dmm} is the local manual setting
  task run(input logic sx, dm, dmm, m_en, m_mst, input logic [2:0] t,
           input logic pma);
    logic tf, flt, mst;
    logic [15:0] tgt;
    int k;
    tf = !(dm | m_en | mlt) && t == 3'h7;
    flt = tf || (dm && m_en && dmm == m_mst);
    tgt = (sx ? 16'h6 : 16'h4) *
          (tf ? 16'h7 : (dm | m_en | mlt) ? 16'h1 : 16'(t) + 16'h1);
    @(posedge clk);
    pma_link_ok <= pma;
    six <= sx;
    pm <= m_en;
    pmm <= m_mst;
    ties <= t;
    p_seed <= 11'(xs());
    lag <= 2'(xs());
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    wr(`GPRR_OFS_CTRL, {27'h0, sx, mlt, dmm, dm, 1'b1});
    k = 0;
    while (n_rx !== tgt && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (n_rx !== tgt) begin
      n_fail++;
      $display("ERROR pages expected %0d seen %0d", tgt, n_rx);
      conclude();
    end
    repeat (8) @(posedge clk);
    n_checks++;
    if (n_bad !== 16'h0000) begin
      n_fail++;
      $display("ERROR page words expected 0 bad seen %0d", n_bad);
    end
    if (flt) mst = 1'b0;
    else if (dm) mst = dmm;
    else if (m_en) mst = !m_mst;
    else if (mlt) mst = 1'b1;
    else mst = ds_q > ps_q;
    ev_m = ev_m | (flt ? 2'h3 : 2'h1);
    // A manual fault has sent exactly one seed page
    rd(`GPRR_OFS_STATUS, {25'h0, tf ? 3'h7 : flt ? 3'h1 : 3'h0,
       pma & !flt, flt, mst, 1'b1}, 32'h7F, 1'b1, "status");
    $display("run finished: fault %0d master %0d", flt, mst);
  endtask : run

  // Takes the oldest note when read data stand and compares
  always @(posedge clk) begin
    if (re_q) begin
      n_checks++;
      if (q.size() == 0) begin
        n_fail++;
        $display("ERROR read expected none seen %h", reg_rdata);
      end else begin
        e = q.pop_front();
        if ((reg_rdata & e.m) !== (e.v & e.m)) begin
          n_fail++;
          $display("ERROR %s expected %h seen %h", e.nm, e.v & e.m,
                   reg_rdata & e.m);
        end
        if (irq !== e.irq_e) begin
          n_fail++;
          $display("ERROR irq expected %b seen %b", e.irq_e, irq);
        end
        if (e.pins && {gigabit_link_state, res_fault, role_master,
            res_done} !== e.v[3:0]) begin
          n_fail++;
          $display("ERROR pins expected %h seen %b%b%b%b", e.v[3:0],
                   gigabit_link_state, res_fault, role_master, res_done);
        end
      end
    end
    re_q = reg_re;
  end

  initial begin
    rs = 32'h03D35895;
    {rst_n, reg_we, reg_re, pma_link_ok, arm, six, pm, pmm, re_q, mlt} =
      10'h000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    p_seed = 11'h0;
    ties = 3'h0;
    lag = 2'h0;
    ev_m = 2'h0;
    en_m = 2'h0;
    n_fail = 0;
    n_checks = 0;
    mt = '{4'hF, 4'hA, 4'hC, 4'h3, 4'hB};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`GPRR_OFS_STATUS, 32'h0, 32'h7F, 1'b1, "status");
    rd(`GPRR_OFS_ABILITY, `GPRR_RST_ABIL, 32'hFFFF, 1'b0, "ability");
    rd(`GPRR_OFS_IRQ_EN, 32'h0, 32'h3, 1'b0, "irq_en");
    rd(8'h3C, 32'h0, 32'hFFFFFFFF, 1'b0, "unmapped");
    wr(`GPRR_OFS_ABILITY, 32'h1234);
    rd(`GPRR_OFS_ABILITY, 32'h1234, 32'hFFFF, 1'b0, "ability");
    $display("register test finished");
    run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b1);
    run(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b1);
    run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
    run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2, 1'b1);
    wr(`GPRR_OFS_IRQ_EN, 32'h3);
    en_m = 2'h3;
    run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h7, 1'b1);
    rd(`GPRR_OFS_IRQ_STAT, 32'h3, 32'h3, 1'b0, "irq_stat");
    wr(`GPRR_OFS_IRQ_CLR, 32'h3);
    ev_m = 2'h0;
    rd(`GPRR_OFS_IRQ_STAT, 32'h0, 32'h3, 1'b0, "irq_stat");
    run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h6, 1'b1);
    wr(`GPRR_OFS_IRQ_EN, 32'h0);
    en_m = 2'h0;
    rd(`GPRR_OFS_IRQ_STAT, 32'h1, 32'h3, 1'b0, "irq_stat");
    $display("interrupt test finished");
    // Local multiport beats a seed tie against a single-port partner
    mlt = 1'b1;
    run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h3, 1'b1);
    rd(`GPRR_OFS_CTRL, 32'h8, 32'h1F, 1'b0, "ctrl");
    mlt = 1'b0;
    for (int i = 0; i < 5; i++) begin
      run(1'b0, mt[i][3], mt[i][2], mt[i][1], mt[i][0], 3'h0, 1'b1);
    end
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : tb
